// file: core/afe_out_pkg.sv
package afe_out_pkg;

    // Register byte addresses (index times four, since printed offsets are not word multiples).
    localparam logic [7:0] IDX_OUTPUT_FORMAT_2 = 8'h29;
    localparam logic [7:0] IDX_HSYNC_WIDTH = 8'h2A;
    localparam logic [7:0] IDX_TRISTATE = 8'h2B;
    localparam logic [7:0] IDX_POWER = 8'h2C;
    localparam logic [9:0] ADDR_OUTPUT_FORMAT_2 = {IDX_OUTPUT_FORMAT_2, 2'b00};
    localparam logic [9:0] ADDR_HSYNC_WIDTH = {IDX_HSYNC_WIDTH, 2'b00};
    localparam logic [9:0] ADDR_TRISTATE = {IDX_TRISTATE, 2'b00};
    localparam logic [9:0] ADDR_POWER = {IDX_POWER, 2'b00};

    // Reset values.
    localparam logic [7:0] RST_OUTPUT_FORMAT_2 = 8'h00;
    localparam logic [7:0] RST_HSYNC_WIDTH = 8'h10;
    localparam logic [7:0] RST_TRISTATE = 8'hFF;
    localparam logic [7:0] RST_POWER = 8'h00;

    // Output format 2 fields.
    localparam int BIT_ANCHOR_EDGE = 4;
    localparam int BIT_XTAL_HALF = 5;
    localparam int BIT_XTAL_ENABLE = 6;

    // Tri-state control fields.
    localparam int BIT_TRI_RED = 0;
    localparam int BIT_TRI_GREEN = 1;
    localparam int BIT_TRI_BLUE = 2;
    localparam int BIT_TRI_SYNC = 3;
    localparam int BIT_TRI_PIXCLK = 4;
    localparam int BIT_TRI_PIXCLK_N = 5;
    localparam int BIT_TRI_VALID = 6;
    localparam int BIT_TRI_FIELD = 7;

    // Power control fields.
    localparam int BIT_PD_RED = 0;
    localparam int BIT_PD_GREEN = 1;
    localparam int BIT_PD_BLUE = 2;
    localparam int BIT_PD_SAMPLE_CLK = 3;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// file: core/xtal_clock_out.sv
`timescale 1ns/100ps
module xtal_clock_out
    import afe_out_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic arst_n,
    // Control.
    input wire logic enable,
    input wire logic half_rate,
    // Output.
    output logic crystal_clock_output
);

    logic phase;
    logic toggle_now;
    logic next_out;

    // The full-rate output is modelled as a toggle every clock; half rate toggles every second.
    assign toggle_now = half_rate ? phase : 1'b1;
    assign next_out = enable ? (crystal_clock_output ^ toggle_now) : 1'b0;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            phase <= 1'b0;
            crystal_clock_output <= 1'b0;
        end else begin
            phase <= enable ? ~phase : 1'b0;
            crystal_clock_output <= next_out;
        end
    end

endmodule // xtal_clock_out

// file: core/hsync_regen.sv
`timescale 1ns/100ps
module hsync_regen
    import afe_out_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic arst_n,
    // Control.
    input wire logic [7:0] width,
    input wire logic anchor_trailing,
    // Sync in, already synchronised, and regenerated pulse out.
    input wire logic sync_edge,
    output logic regenerated_hsync_output
);

    // Trailing-anchored pulses need to start before the reference edge, so the output is
    // delayed by a full 255-pixel window; the leading-anchored path gets the same delay
    // to keep both modes at one latency.
    logic [8:0] count;
    logic [8:0] next_count;
    logic active;
    logic next_active;
    logic [8:0] start_at;
    logic [8:0] stop_at;

    assign start_at = anchor_trailing ? 9'd255 - {1'b0, width} : 9'd255;
    assign stop_at = anchor_trailing ? 9'd255 : 9'd255 + {1'b0, width};
    assign next_count = sync_edge ? 9'd0 : (count == 9'h1FF ? count : count + 9'd1);
    // A saturated counter means no recent sync, so no pulse may start from it.
    assign next_active = (next_count >= start_at) && (next_count < stop_at) &&
                         (count != 9'h1FF || sync_edge);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            count <= 9'h1FF;
            active <= 1'b0;
        end else begin
            count <= next_count;
            active <= next_active;
        end
    end

    assign regenerated_hsync_output = active;

endmodule // hsync_regen

// file: core/afe_output_power_control.sv
`timescale 1ns/100ps
// Summary of operation
// - Bit 5 of output format picks full or half crystal rate on the crystal clock output.
// - Bit 6 enables the crystal clock output, which is held low when the bit is clear.
// - The regenerated hsync pulse lasts the programmed 8-bit pixel count, reset value 16.
// - The anchor setting fixes one pulse edge to the input sync and the width extends from it.
// - Anchor 0 fixes the leading edge, anchor 1 fixes the trailing edge and moves the lead.
// - The tri-state register resets to all ones so every digital output except the crystal clock output starts undriven.
// - Tri-state bits 0 to 2 release the red, green and blue data pins when set.
// - Tri-state bit 3 releases the hsync, buffered hsync and vsync outputs together.
// - Tri-state bits 4 to 7 release pixel clock, its inverse, data valid and field.
// - Power bits 0 to 2 power down the red, green and blue converters; reset is zero.
// - Power bit 3 powers down the sampling clock generator when set.
module afe_output_power_control
    import afe_out_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic arst_n,
    // AXI4-Lite write address.
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address.
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Input sync from the pin.
    input wire logic input_hsync,
    // Core-side pixel stream to be driven out.
    input wire logic [7:0] red_data,
    input wire logic [7:0] green_data,
    input wire logic [7:0] blue_data,
    input wire logic buffered_hsync,
    input wire logic buffered_vsync,
    input wire logic pixel_clock,
    input wire logic data_valid,
    input wire logic field,
    // Output pins with enables.
    output logic [7:0] red_out,
    output logic [7:0] green_out,
    output logic [7:0] blue_out,
    output logic [2:0] data_oe,
    output logic regenerated_hsync_output,
    output logic hsync_buffered_out,
    output logic vsync_buffered_out,
    output logic sync_oe,
    output logic pixel_clock_output,
    output logic pixel_clock_output_oe,
    output logic pixel_clock_output_inverted,
    output logic pixel_clock_output_inverted_oe,
    output logic data_valid_output,
    output logic data_valid_output_oe,
    output logic field_output,
    output logic field_output_oe,
    output logic crystal_clock_output,
    // Power controls to the analogue section.
    output logic [2:0] converter_power_down,
    output logic sample_clock_power_down
);

    ////////////////////////////////////////////////////////////////////////////////

    logic [7:0] output_format_2;
    logic [7:0] hsync_out_pulse_width;
    logic [7:0] output_tristate_control;
    logic [7:0] channel_power_control;

    logic aw_held;
    logic w_held;
    logic [9:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic write_hit;
    logic read_hit;
    logic [7:0] read_value;

    function automatic logic addr_hit(input logic [9:0] a);
        addr_hit = (a == ADDR_OUTPUT_FORMAT_2) || (a == ADDR_HSYNC_WIDTH) ||
                   (a == ADDR_TRISTATE) || (a == ADDR_POWER);
    endfunction

    function automatic logic [7:0] reg_next(input logic [7:0] cur, input logic [9:0] a,
                                            input logic [9:0] target);
        reg_next = (a == target && w_strb[0]) ? w_data[7:0] : cur;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Write path: address and data are caught in either order, then one response.

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign write_hit = addr_hit(aw_addr);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            aw_held <= 1'b0;
            aw_addr <= 10'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr[9:0];
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= write_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            output_format_2 <= RST_OUTPUT_FORMAT_2;
            hsync_out_pulse_width <= RST_HSYNC_WIDTH;
            output_tristate_control <= RST_TRISTATE;
            channel_power_control <= RST_POWER;
        end else if (do_write) begin
            output_format_2 <= reg_next(output_format_2, aw_addr, ADDR_OUTPUT_FORMAT_2);
            hsync_out_pulse_width <= reg_next(hsync_out_pulse_width, aw_addr, ADDR_HSYNC_WIDTH);
            output_tristate_control <= reg_next(output_tristate_control, aw_addr, ADDR_TRISTATE);
            channel_power_control <= reg_next(channel_power_control, aw_addr, ADDR_POWER);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path: one cycle from address to data; unmapped reads answer SLVERR with zero.

    assign s_axi_arready = !s_axi_rvalid;
    assign read_hit = addr_hit(s_axi_araddr[9:0]);
    assign read_value = (s_axi_araddr[9:0] == ADDR_OUTPUT_FORMAT_2) ? output_format_2 :
                        (s_axi_araddr[9:0] == ADDR_HSYNC_WIDTH) ? hsync_out_pulse_width :
                        (s_axi_araddr[9:0] == ADDR_TRISTATE) ? output_tristate_control :
                        (s_axi_araddr[9:0] == ADDR_POWER) ? channel_power_control : 8'h00;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, read_value};
            s_axi_rresp <= read_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sync input: two flops, then a rising-edge detect on the second stage.

    logic hs_meta;
    logic hs_sync;
    logic hs_last;
    logic hs_edge;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hs_meta <= 1'b0;
            hs_sync <= 1'b0;
            hs_last <= 1'b0;
        end else begin
            hs_meta <= input_hsync;
            hs_sync <= hs_meta;
            hs_last <= hs_sync;
        end
    end

    assign hs_edge = hs_sync && !hs_last;

    hsync_regen u_hsync_regen (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .width(hsync_out_pulse_width),
        .anchor_trailing(output_format_2[BIT_ANCHOR_EDGE]),
        .sync_edge(hs_edge),
        .regenerated_hsync_output(regenerated_hsync_output)
    );

    xtal_clock_out u_xtal_clock_out (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .enable(output_format_2[BIT_XTAL_ENABLE]),
        .half_rate(output_format_2[BIT_XTAL_HALF]),
        .crystal_clock_output(crystal_clock_output)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Output data registers and pin enables.

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            red_out <= 8'h00;
            green_out <= 8'h00;
            blue_out <= 8'h00;
            hsync_buffered_out <= 1'b0;
            vsync_buffered_out <= 1'b0;
            pixel_clock_output <= 1'b0;
            pixel_clock_output_inverted <= 1'b1;
            data_valid_output <= 1'b0;
            field_output <= 1'b0;
        end else begin
            red_out <= red_data;
            green_out <= green_data;
            blue_out <= blue_data;
            hsync_buffered_out <= buffered_hsync;
            vsync_buffered_out <= buffered_vsync;
            pixel_clock_output <= pixel_clock;
            pixel_clock_output_inverted <= ~pixel_clock;
            data_valid_output <= data_valid;
            field_output <= field;
        end
    end

    assign data_oe = ~{output_tristate_control[BIT_TRI_BLUE],
                       output_tristate_control[BIT_TRI_GREEN],
                       output_tristate_control[BIT_TRI_RED]};
    assign sync_oe = ~output_tristate_control[BIT_TRI_SYNC];
    assign pixel_clock_output_oe = ~output_tristate_control[BIT_TRI_PIXCLK];
    assign pixel_clock_output_inverted_oe = ~output_tristate_control[BIT_TRI_PIXCLK_N];
    assign data_valid_output_oe = ~output_tristate_control[BIT_TRI_VALID];
    assign field_output_oe = ~output_tristate_control[BIT_TRI_FIELD];

    assign converter_power_down = {channel_power_control[BIT_PD_BLUE],
                                   channel_power_control[BIT_PD_GREEN],
                                   channel_power_control[BIT_PD_RED]};
    assign sample_clock_power_down = channel_power_control[BIT_PD_SAMPLE_CLK];

endmodule // afe_output_power_control

// file: tb/afe_output_power_control_properties.sv
`timescale 1ns/100ps
module afe_output_power_control_properties
    import afe_out_pkg::*;
(
    // Clock, reset and write channels.
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    // Watched outputs.
    input wire logic [2:0] data_oe,
    input wire logic sync_oe,
    input wire logic pixel_clock_output_oe,
    input wire logic pixel_clock_output_inverted_oe,
    input wire logic data_valid_output_oe,
    input wire logic field_output_oe,
    input wire logic crystal_clock_output,
    input wire logic regenerated_hsync_output,
    input wire logic [2:0] converter_power_down,
    input wire logic sample_clock_power_down
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Shadows commit one edge after the register, so checks skip the first answer cycle.
    logic [9:0] pend_addr;
    logic [7:0] pend_data, sh_fmt, sh_width, sh_tri, sh_pwr;
    logic bvalid_q, pend_en;
    wire logic fresh = s_axi_bvalid && !bvalid_q;
    // A write without the low byte lane leaves the register as it was.
    wire logic commit = fresh && pend_en && s_axi_bresp == RESP_OKAY;
    wire logic on = sh_fmt[BIT_XTAL_ENABLE];
    wire logic half = sh_fmt[BIT_XTAL_HALF];
    wire logic [7:0] oe_all = {field_output_oe, data_valid_output_oe,
        pixel_clock_output_inverted_oe, pixel_clock_output_oe, sync_oe, data_oe};
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pend_addr <= 10'h000;
            pend_data <= 8'h00;
            pend_en <= 1'b0;
            bvalid_q <= 1'b0;
            sh_fmt <= RST_OUTPUT_FORMAT_2;
            sh_width <= RST_HSYNC_WIDTH;
            sh_tri <= RST_TRISTATE;
            sh_pwr <= RST_POWER;
        end else begin
            bvalid_q <= s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
                pend_addr <= s_axi_awaddr[9:0];
            if (s_axi_wvalid && s_axi_wready) begin
                pend_data <= s_axi_wdata[7:0];
                pend_en <= s_axi_wstrb[0];
            end
            if (commit && pend_addr == ADDR_OUTPUT_FORMAT_2)
                sh_fmt <= pend_data;
            if (commit && pend_addr == ADDR_HSYNC_WIDTH)
                sh_width <= pend_data;
            if (commit && pend_addr == ADDR_TRISTATE)
                sh_tri <= pend_data;
            if (commit && pend_addr == ADDR_POWER)
                sh_pwr <= pend_data;
        end
    end
    sequence off_run; (!on && !fresh) [*2]; endsequence
    sequence full_run; (on && !half && !fresh) [*3]; endsequence
    sequence half_run; (on && half && !fresh) [*4]; endsequence
    sequence zero_run; (sh_width == 8'h00 && !fresh) [*8]; endsequence
    reset_state_a: assert property ($rose(arst_n) |-> oe_all == 8'h00
        && converter_power_down == 3'b000 && !sample_clock_power_down)
        else $error("outputs not released after reset");
    data_oe_a: assert property (!fresh |-> data_oe == ~sh_tri[2:0])
        else $error("colour enables wrong");
    sync_oe_a: assert property (!fresh |-> sync_oe == !sh_tri[BIT_TRI_SYNC])
        else $error("sync enable wrong");
    clock_group_a: assert property (!fresh |-> oe_all[7:4] == ~sh_tri[7:4])
        else $error("clock group enables wrong");
    power_map_a: assert property (!fresh |-> converter_power_down == sh_pwr[2:0])
        else $error("converter power wrong");
    sample_pd_a: assert property (!fresh |-> sample_clock_power_down == sh_pwr[3])
        else $error("sampling clock power wrong");
    xtal_low_a: assert property (off_run |-> !crystal_clock_output)
        else $error("crystal output not low");
    xtal_full_a: assert property (full_run |-> $changed(crystal_clock_output))
        else $error("crystal output missed a toggle");
    xtal_half_a: assert property (half_run |->
        $changed(crystal_clock_output) != $changed($past(crystal_clock_output)))
        else $error("crystal output not at half rate");
    hsync_quiet_a: assert property (zero_run |-> !regenerated_hsync_output)
        else $error("pulse with zero width");
endmodule // afe_output_power_control_properties

bind afe_output_power_control afe_output_power_control_properties props_inst (.*);

// file: tb/video_sink_model.sv
`timescale 1ns/100ps
module video_sink_model (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic arst_n,
    // Sync pins seen by the receiver.
    input wire logic input_hsync,
    input wire logic regenerated_hsync_output,
    input wire logic sync_oe,
    // Pulse edges, in cycles after the input sync rose.
    output logic [11:0] rise_at,
    output logic [11:0] fall_at,
    output logic [7:0] pulses
);
    // A released pin shows the inverse level, so a floating line never looks valid.
    wire logic pin = sync_oe ? regenerated_hsync_output : ~regenerated_hsync_output;
    logic [11:0] since;
    logic pin_q, ref_q;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            since <= 12'h000;
            pin_q <= 1'b0;
            ref_q <= 1'b0;
            rise_at <= 12'h000;
            fall_at <= 12'h000;
            pulses <= 8'h00;
        end else begin
            ref_q <= input_hsync;
            pin_q <= pin;
            since <= (input_hsync && !ref_q) ? 12'h000 : since + 12'h001;
            if (pin && !pin_q)
                rise_at <= since;
            if (!pin && pin_q) begin
                fall_at <= since;
                pulses <= pulses + 8'h01;
            end
        end
    end
endmodule // video_sink_model

// file: tb/tb.sv
`timescale 1ns/100ps
module tb;
    import afe_out_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, input_hsync = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [31:0] pix = 32'h0;
    wire logic [7:0] red_data = pix[7:0], green_data = pix[15:8], blue_data = pix[23:16];
    wire logic buffered_hsync = pix[24], buffered_vsync = pix[25], pixel_clock = pix[0];
    wire logic data_valid = pix[26], field = pix[27];
    logic [7:0] red_out, green_out, blue_out, pulses, p0;
    logic [2:0] data_oe, converter_power_down;
    logic regenerated_hsync_output, hsync_buffered_out, vsync_buffered_out, sync_oe;
    logic pixel_clock_output, pixel_clock_output_oe, pixel_clock_output_inverted;
    logic pixel_clock_output_inverted_oe, data_valid_output, data_valid_output_oe;
    logic field_output, field_output_oe, crystal_clock_output, sample_clock_power_down;
    logic [11:0] rise_at, fall_at, ref_at;
    logic [31:0] q;
    wire logic [31:0] outs_all = {2'b00, pixel_clock_output_inverted, pixel_clock_output,
        field_output, data_valid_output, vsync_buffered_out, hsync_buffered_out,
        blue_out, green_out, red_out};
    logic [7:0] widths [3] = '{8'h01, 8'h28, 8'hFF};
    int err_total = 0;
    int compares = 0;
    int t;
    wire logic [7:0] oe_all = {field_output_oe, data_valid_output_oe,
        pixel_clock_output_inverted_oe, pixel_clock_output_oe, sync_oe, data_oe};
    wire logic [31:0] pd_all = {28'h0, sample_clock_power_down, converter_power_down};

    afe_output_power_control afe_output_power_control_inst (.*);
    video_sink_model video_sink_model_inst (.*);

    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) pix <= pix + 32'h1;
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk_sys);
        s_axi_awaddr <= {22'h0, a};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 64);
        chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, er});
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk_sys);
        s_axi_araddr <= {22'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 64);
        chk(s_axi_rdata, {24'h0, ed});
        chk({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, er});
        s_axi_rready <= 1'b0;
    endtask
    task automatic xcount(output int c);
        logic p;
        c = 0;
        p = crystal_clock_output;
        repeat (8) begin
            @(posedge clk_sys);
            if (crystal_clock_output !== p)
                c++;
            p = crystal_clock_output;
        end
    endtask
    // Long enough for the widest pulse, which ends about 510 cycles after the sync.
    task automatic pulse;
        @(posedge clk_sys);
        input_hsync <= 1'b1;
        repeat (4) @(posedge clk_sys);
        input_hsync <= 1'b0;
        repeat (600) @(posedge clk_sys);
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(ADDR_OUTPUT_FORMAT_2, 8'h00, RESP_OKAY);
        rd(ADDR_HSYNC_WIDTH, 8'h10, RESP_OKAY);
        rd(ADDR_TRISTATE, 8'hFF, RESP_OKAY);
        rd(ADDR_POWER, 8'h00, RESP_OKAY);
        chk({24'h0, oe_all}, 32'h0);
        chk(pd_all, 32'h0);
        // Every pin level is the core input of one clock earlier; the inverted pixel clock is its inverse.
        q = pix - 32'h1;
        chk(outs_all, {2'b00, ~q[0], q[0], q[27:0]});
        xcount(t);
        chk(t + crystal_clock_output, 0);
        wr(10'h0B4, 8'h5A, RESP_SLVERR);
        rd(10'h0B4, 8'h00, RESP_SLVERR);
        $display("reset and unmapped tests done");
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_TRISTATE, ~(8'h01 << i), RESP_OKAY);
            rd(ADDR_TRISTATE, ~(8'h01 << i), RESP_OKAY);
            chk({24'h0, oe_all}, 32'h1 << i);
        end
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_POWER, 8'h01 << i, RESP_OKAY);
            chk(pd_all, 32'h1 << i);
        end
        wr(ADDR_POWER, 8'h00, RESP_OKAY);
        s_axi_wstrb <= 4'hE;
        wr(ADDR_POWER, 8'h0F, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(ADDR_POWER, 8'h00, RESP_OKAY);
        $display("tri-state and power tests done");
        wr(ADDR_OUTPUT_FORMAT_2, 8'h40, RESP_OKAY);
        xcount(t);
        chk(t, 8);
        wr(ADDR_OUTPUT_FORMAT_2, 8'h60, RESP_OKAY);
        xcount(t);
        chk(t, 4);
        $display("crystal output tests done");
        wr(ADDR_TRISTATE, 8'h00, RESP_OKAY);
        pulse();
        for (int a = 0; a < 2; a++) begin
            wr(ADDR_OUTPUT_FORMAT_2, (a == 1) ? 8'h10 : 8'h00, RESP_OKAY);
            for (int k = 0; k < 3; k++) begin
                wr(ADDR_HSYNC_WIDTH, widths[k], RESP_OKAY);
                p0 = pulses;
                pulse();
                if (k == 0)
                    ref_at = (a == 1) ? fall_at : rise_at;
                chk({24'h0, pulses}, {24'h0, p0 + 8'h01});
                chk({20'h0, fall_at - rise_at}, {24'h0, widths[k]});
                chk({20'h0, (a == 1) ? fall_at : rise_at}, {20'h0, ref_at});
            end
        end
        wr(ADDR_HSYNC_WIDTH, 8'h00, RESP_OKAY);
        p0 = pulses;
        pulse();
        chk({24'h0, pulses}, {24'h0, p0});
        $display("sync pulse tests done");
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        wrap_up();
    end
endmodule // tb
